// *** design/xrcc_pkg.sv ***
// Purpose: Shared constants for the receive clock compensation block
// Assumes: 100 MHz core clock, 8-bit register port
// Notes:   Column layout is {ctrl[3:0], data[31:0]}, lane n in byte n
package xrcc_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_NS = 10;
	localparam int RD_NS  = 80;
	localparam int RD_DIV = (RD_NS / CLK_NS) < 1 ? 1 : (RD_NS / CLK_NS);
	// ==========================================================
	// Buffers
	localparam int FIFO_DEPTH = 16;
	localparam int PTR_W      = 4;
	localparam int PH_DEPTH   = 4;
	localparam int PH_PTR_W   = 2;
	localparam int COL_W      = 36;
	localparam int GAP_W      = 3;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_LANE_CTRL = 8'h00;
	localparam logic [7:0] OFS_ALIGN_EN  = 8'h04;
	localparam logic [7:0] OFS_WATER     = 8'h0d;
	localparam logic [7:0] OFS_GAP       = 8'h0e;
	localparam logic [7:0] OFS_PAT_LO    = 8'h12;
	localparam logic [7:0] OFS_PAT_HI    = 8'h13;
	localparam logic [7:0] OFS_EV_EN     = 8'h20;
	localparam logic [7:0] OFS_ALIGN_ST  = 8'h82;
	localparam logic [7:0] OFS_LSM_ST    = 8'h84;
	localparam logic [7:0] OFS_FIFO_ST   = 8'h85;
	localparam logic [7:0] OFS_EV_FLAGS  = 8'h8a;
	// ==========================================================
	// Field positions
	localparam int BIT_FELB    = 5;
	localparam int BIT_LSM_EN  = 7;
	localparam int BIT_ALIGNED = 2;
	localparam int BIT_URUN    = 6;
	localparam int BIT_ORUN    = 7;
	localparam int BIT_GAP_A   = 6;
	localparam int BIT_GAP_B   = 7;
	localparam int BIT_PAT_K   = 0;
	localparam int LSM_LSB     = 4;
	localparam int ALIGN_MSB   = 7;
	localparam int EV_ALIGNED  = 4;
	localparam int EV_URUN     = 5;
	localparam int EV_ORUN     = 6;
	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_LANE_CTRL = 8'h00;
	localparam logic [7:0] RST_ALIGN_EN  = 8'h00;
	localparam logic [7:0] RST_WATER     = 8'h97;
	localparam logic [7:0] RST_GAP       = 8'h00;
	localparam logic [7:0] RST_PAT_LO    = 8'h1c;
	localparam logic [7:0] RST_PAT_HI    = 8'h01;
	localparam logic [7:0] RST_EV_EN     = 8'h00;
	// ==========================================================
	// Code groups
	localparam logic [7:0] K_SKIP  = 8'h1c;
	localparam logic [7:0] K_ALIGN = 8'h7c;
	localparam logic [7:0] K_SYNC  = 8'hbc;
	localparam logic [7:0] X_IDLE  = 8'h07;
	localparam logic [7:0] X_TERM  = 8'hfd;
	localparam logic [7:0] X_ERR   = 8'hfe;
	localparam logic [7:0] LF_L0   = 8'h9c;
	localparam logic [7:0] LF_L1   = 8'h00;
	localparam logic [7:0] LF_L2   = 8'h00;
	localparam logic [7:0] LF_L3   = 8'h01;
	localparam logic [3:0] LF_CTRL = 4'h1;
	typedef enum logic {RD_POP, RD_HELD} xrcc_rd_e;
endpackage

// *** design/xrcc_phase_fifo.sv ***
// Purpose: Phase-only FIFO between two equal-rate clock points
// Assumes: Writer and reader share one frequency
// Notes:   Cannot absorb a rate difference; overflow drops the word
`timescale 1ns/10ps
`default_nettype none
module xrcc_phase_fifo
	import xrcc_pkg::*;
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Write side
	input  wire logic [COL_W-1:0] in_data,
	input  wire logic             in_valid,
	// Read side
	output logic      [COL_W-1:0] out_data,
	output logic                  out_valid
);
	logic [COL_W-1:0] mem [PH_DEPTH];
	logic [PH_PTR_W:0] wr_ptr_ff;
	logic [PH_PTR_W:0] rd_ptr_ff;
	logic              empty;
	logic              full;

	assign empty = (wr_ptr_ff == rd_ptr_ff);
	assign full  = (wr_ptr_ff - rd_ptr_ff) == (PH_PTR_W + 1)'(PH_DEPTH);

	always_ff @(posedge clk) begin
		if (in_valid && !full)
			mem[wr_ptr_ff[PH_PTR_W-1:0]] <= in_data;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else begin
			if (in_valid && !full)
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (!empty)
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_data  <= '0;
			out_valid <= 1'b0;
		end else begin
			out_valid <= !empty;
			if (!empty)
				out_data <= mem[rd_ptr_ff[PH_PTR_W-1:0]];
		end
	end
endmodule // xrcc_phase_fifo
`default_nettype wire

// *** design/xrcc_rx_comp.sv ***
// Purpose: Receive clock compensation, XGMII mapping, control and status
// Assumes: Aligner clock and status pins are asynchronous to clk
// Notes:   All lanes share one column FIFO, so lane flags match
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module xrcc_rx_comp
	import xrcc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Aligner side
	input  wire logic        algn_clk,
	input  wire logic [31:0] algn_data,
	input  wire logic [3:0]  algn_ctrl,
	// Asynchronous status pins
	input  wire logic        lane0_active,
	input  wire logic [3:0]  lsm_status,
	input  wire logic        algn_aligned,
	input  wire logic        resync,
	// Fabric control
	input  wire logic        felb_pin,
	input  wire logic        lsm_en_pin,
	input  wire logic        align_en_pin,
	// Fabric transmit
	input  wire logic [31:0] tx_data,
	input  wire logic [3:0]  tx_ctrl,
	input  wire logic        tx_valid,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Fabric receive
	output logic      [31:0] rxd,
	output logic      [3:0]  rxc,
	output logic             rx_valid,
	// Transmit to line
	output logic      [31:0] txo_data,
	output logic      [3:0]  txo_ctrl,
	output logic             txo_valid,
	// Control and status out
	output logic             loopback_on,
	output logic             lsm_enable,
	output logic             lsm_restart,
	output logic      [3:0]  align_lane_en,
	output logic             align_resync,
	output logic      [3:0]  lsm_sync,
	output logic             aligned,
	output logic      [3:0]  ctc_underrun,
	output logic      [3:0]  ctc_overrun
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ==========================================================
	// Helpers
	function automatic logic to_idle(input logic [7:0] d, input logic k);
		to_idle = k && (d == K_SKIP || d == K_ALIGN || d == K_SYNC);
	endfunction

	function automatic logic is_pat(input logic [7:0] d, input logic k,
		input logic [7:0] lo, input logic [7:0] hi);
		is_pat = (d == lo) && (k == hi[BIT_PAT_K]);
	endfunction

	// ==========================================================
	// Input synchronisers: bit 0 lane0, 4:1 link sync, 5 aligned, 6 resync
	localparam int NSYNC = 7;
	logic [NSYNC-1:0] s1_ff;
	logic [NSYNC-1:0] s2_ff;
	logic [NSYNC-1:0] s3_ff;
	logic [NSYNC-1:0] filt_ff;
	logic [2:0]       ac_ff;
	logic             alg_lvl_ff;
	logic             alg_rise;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			ac_ff <= '0;
		end else begin
			s1_ff <= {resync, algn_aligned, lsm_status, lane0_active};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			ac_ff <= {ac_ff[1:0], algn_clk};
		end
	end

	// A change counts only once the last two stages agree
	generate
		for (genvar i = 0; i < NSYNC; i++) begin : g_filt
			always_ff @(posedge clk) begin
				if (!rst_n)
					filt_ff[i] <= 1'b0;
				else if (s2_ff[i] == s3_ff[i])
					filt_ff[i] <= s3_ff[i];
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n)
			alg_lvl_ff <= 1'b0;
		else if (ac_ff[1] == ac_ff[2])
			alg_lvl_ff <= ac_ff[2];
	end
	assign alg_rise = ac_ff[1] && ac_ff[2] && !alg_lvl_ff;

	// ==========================================================
	// Registers
	logic [7:0] lane_ctrl_ff;
	logic [7:0] align_en_ff;
	logic [7:0] water_ff;
	logic [7:0] gap_reg_ff;
	logic [7:0] pat_lo_ff;
	logic [7:0] pat_hi_ff;
	logic [7:0] ev_en_ff;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lane_ctrl_ff <= RST_LANE_CTRL;
			align_en_ff  <= RST_ALIGN_EN;
			water_ff     <= RST_WATER;
			gap_reg_ff   <= RST_GAP;
			pat_lo_ff    <= RST_PAT_LO;
			pat_hi_ff    <= RST_PAT_HI;
			ev_en_ff     <= RST_EV_EN;
		end else if (reg_wr) begin
			case (reg_addr)
				OFS_LANE_CTRL: lane_ctrl_ff <= reg_wdata;
				OFS_ALIGN_EN:  align_en_ff  <= reg_wdata;
				OFS_WATER:     water_ff     <= reg_wdata;
				OFS_GAP:       gap_reg_ff   <= reg_wdata;
				OFS_PAT_LO:    pat_lo_ff    <= reg_wdata;
				OFS_PAT_HI:    pat_hi_ff    <= reg_wdata;
				OFS_EV_EN:     ev_en_ff     <= reg_wdata;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Elastic FIFO, one column of all four lanes per entry
	logic [COL_W-1:0] emem [FIFO_DEPTH];
	logic [PTR_W:0]   ewr_ff;
	logic [PTR_W:0]   erd_ff;
	logic [PTR_W:0]   level;
	logic [3:0]       hi_mark;
	logic [3:0]       lo_mark;
	logic [GAP_W-1:0] min_gap;
	logic [GAP_W-1:0] gap_ff;
	logic             lane0_ok;
	logic             wr_go;
	logic             del;
	logic             do_wr;
	logic             orun_ev;
	logic             full;
	logic             empty;

	assign lane0_ok = filt_ff[0];
	assign level    = ewr_ff - erd_ff;
	assign full     = level == (PTR_W + 1)'(FIFO_DEPTH);
	assign empty    = level == '0;
	assign hi_mark  = water_ff[7:4];
	assign lo_mark  = water_ff[3:0];
	// One column per deletion, so the minimum gap is the multiplier plus one
	assign min_gap  = GAP_W'({gap_reg_ff[BIT_GAP_A], gap_reg_ff[BIT_GAP_B]}) + 1'b1;
	assign wr_go    = alg_rise && lane0_ok;
	assign del      = wr_go && is_pat(algn_data[7:0], algn_ctrl[0], pat_lo_ff, pat_hi_ff)
		&& (level >= {1'b0, hi_mark}) && (gap_ff >= min_gap);
	assign do_wr    = wr_go && !del && !full;
	assign orun_ev  = wr_go && !del && full;

	// Inter-packet run length seen on lane 0
	always_ff @(posedge clk) begin
		if (!rst_n)
			gap_ff <= '0;
		else if (wr_go) begin
			if (!algn_ctrl[0])
				gap_ff <= '0;
			else if (gap_ff != '1)
				gap_ff <= gap_ff + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (do_wr)
			emem[ewr_ff[PTR_W-1:0]] <= {algn_ctrl, algn_data};
	end

	// Read side on the reference clock rate
	logic [7:0]       tick_ff;
	logic             rd_go;
	logic [COL_W-1:0] head;
	logic             ins;
	logic             pop;
	logic             urun_ev;
	xrcc_rd_e         rd_st_ff;

	assign rd_go   = (tick_ff == 8'(RD_DIV - 1)) && lane0_ok;
	assign head    = emem[erd_ff[PTR_W-1:0]];
	assign urun_ev = rd_go && empty;
	// Repeat a skip column once, never twice in a row
	assign ins     = rd_go && !empty && rd_st_ff == RD_POP
		&& is_pat(head[7:0], head[32], pat_lo_ff, pat_hi_ff)
		&& (level <= {1'b0, lo_mark});
	assign pop     = rd_go && !empty && !ins;

	always_ff @(posedge clk) begin
		if (!rst_n)
			tick_ff <= '0;
		else if (tick_ff == 8'(RD_DIV - 1))
			tick_ff <= '0;
		else
			tick_ff <= tick_ff + 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ewr_ff   <= '0;
			erd_ff   <= '0;
			rd_st_ff <= RD_POP;
		end else begin
			if (do_wr)
				ewr_ff <= ewr_ff + 1'b1;
			if (pop)
				erd_ff <= erd_ff + 1'b1;
			case (rd_st_ff)
				RD_POP:  if (ins) rd_st_ff <= RD_HELD;
				RD_HELD: if (pop) rd_st_ff <= RD_POP;
				default: rd_st_ff <= RD_POP;
			endcase
		end
	end

	// ==========================================================
	// Column stage and XGMII mapping
	logic [COL_W-1:0] col_ff;
	logic             col_vld_ff;
	logic [COL_W-1:0] dec_ff;
	logic             dec_vld_ff;
	logic [COL_W-1:0] nxt_dec;
	logic             bad_term;
	logic             seen_term;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			col_ff     <= '0;
			col_vld_ff <= 1'b0;
		end else begin
			col_vld_ff <= rd_go && !empty;
			if (rd_go && !empty)
				col_ff <= head;
		end
	end

	always_comb begin
		nxt_dec   = col_ff;
		bad_term  = 1'b0;
		seen_term = 1'b0;
		for (int n = 0; n < 4; n++) begin
			if (to_idle(col_ff[8*n +: 8], col_ff[32+n]))
				nxt_dec[8*n +: 8] = X_IDLE;
			// Lanes after a terminate must carry idle class groups
			if (seen_term && !to_idle(col_ff[8*n +: 8], col_ff[32+n]))
				bad_term = 1'b1;
			if (col_ff[32+n] && col_ff[8*n +: 8] == X_TERM)
				seen_term = 1'b1;
		end
		if (!filt_ff[5])
			nxt_dec = {LF_CTRL, LF_L3, LF_L2, LF_L1, LF_L0};
		else if (bad_term)
			nxt_dec = {4'hf, {4{X_ERR}}};
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dec_ff     <= '0;
			dec_vld_ff <= 1'b0;
		end else begin
			dec_vld_ff <= col_vld_ff;
			if (col_vld_ff)
				dec_ff <= nxt_dec;
		end
	end

	// ==========================================================
	// Phase FIFOs toward fabric and line
	logic [COL_W-1:0] rx_q;
	logic [COL_W-1:0] tx_q;
	logic [COL_W-1:0] tx_in;
	logic             tx_in_vld;
	logic             felb_eff;

	assign felb_eff  = felb_pin || lane_ctrl_ff[BIT_FELB];
	// Loopback takes the compensated column before fabric mapping
	assign tx_in     = felb_eff ? col_ff : {tx_ctrl, tx_data};
	assign tx_in_vld = felb_eff ? col_vld_ff : tx_valid;

	xrcc_phase_fifo u_rx_phase (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_data   (dec_ff),
		.in_valid  (dec_vld_ff),
		.out_data  (rx_q),
		.out_valid (rx_valid)
	);

	xrcc_phase_fifo u_tx_phase (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_data   (tx_in),
		.in_valid  (tx_in_vld),
		.out_data  (tx_q),
		.out_valid (txo_valid)
	);

	assign rxd      = rx_q[31:0];
	assign rxc      = rx_q[35:32];
	assign txo_data = tx_q[31:0];
	assign txo_ctrl = tx_q[35:32];

	// ==========================================================
	// Control outputs
	logic lsm_eff;
	logic rd_fifo_st;
	logic rd_ev;

	assign lsm_eff    = lsm_en_pin || lane_ctrl_ff[BIT_LSM_EN];
	assign rd_fifo_st = reg_rd && reg_addr == OFS_FIFO_ST;
	assign rd_ev      = reg_rd && reg_addr == OFS_EV_FLAGS;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			loopback_on  <= 1'b0;
			lsm_enable   <= 1'b0;
			lsm_restart  <= 1'b0;
			align_resync <= 1'b0;
			lsm_sync     <= '0;
			aligned      <= 1'b0;
		end else begin
			loopback_on  <= felb_eff;
			lsm_enable   <= lsm_eff;
			lsm_restart  <= lsm_eff != lsm_enable;
			align_resync <= filt_ff[6];
			lsm_sync     <= filt_ff[4:1];
			aligned      <= filt_ff[5];
		end
	end

	generate
		for (genvar n = 0; n < 4; n++) begin : g_lane
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					align_lane_en[n] <= 1'b0;
					ctc_underrun[n]  <= 1'b0;
					ctc_overrun[n]   <= 1'b0;
				end else begin
					align_lane_en[n] <= align_en_pin || align_en_ff[ALIGN_MSB-n];
					// A new event beats the read that clears it
					if (urun_ev)
						ctc_underrun[n] <= 1'b1;
					else if (rd_fifo_st)
						ctc_underrun[n] <= 1'b0;
					if (orun_ev)
						ctc_overrun[n] <= 1'b1;
					else if (rd_fifo_st)
						ctc_overrun[n] <= 1'b0;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Sticky events: 3:0 link sync, 4 aligned, 5 underrun, 6 overrun
	logic [6:0] ev_src;
	logic [6:0] ev_prev_ff;
	logic [6:0] ev_ff;
	logic [6:0] ev_set;

	assign ev_src = {ctc_overrun[0], ctc_underrun[0], aligned, lsm_sync};
	assign ev_set = ev_en_ff[6:0] & ((ev_src & ~ev_prev_ff) | ({7{rd_ev}} & ev_src));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ev_prev_ff <= '0;
			ev_ff      <= '0;
		end else begin
			ev_prev_ff <= ev_src;
			ev_ff      <= (rd_ev ? 7'h00 : ev_ff) | ev_set;
		end
	end

	// ==========================================================
	// Read port, data in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rst_n)
			reg_rdata <= '0;
		else if (reg_rd) begin
			case (reg_addr)
				OFS_LANE_CTRL: reg_rdata <= lane_ctrl_ff;
				OFS_ALIGN_EN:  reg_rdata <= align_en_ff;
				OFS_WATER:     reg_rdata <= water_ff;
				OFS_GAP:       reg_rdata <= gap_reg_ff;
				OFS_PAT_LO:    reg_rdata <= pat_lo_ff;
				OFS_PAT_HI:    reg_rdata <= pat_hi_ff;
				OFS_EV_EN:     reg_rdata <= ev_en_ff;
				OFS_ALIGN_ST:  reg_rdata <= 8'(aligned) << BIT_ALIGNED;
				OFS_LSM_ST:    reg_rdata <= {lsm_sync, 4'h0};
				OFS_FIFO_ST:   reg_rdata <= {ctc_overrun[0], ctc_underrun[0], 6'h00};
				OFS_EV_FLAGS:  reg_rdata <= {1'b0, ev_ff};
				default:       reg_rdata <= 8'h00;
			endcase
		end else
			reg_rdata <= 8'h00;
	end

	// ==========================================================
	// Checks
	AST_FIFO_BOUND: assert property (level <= 5'h10)
		else $error("elastic level above depth");
	AST_OVERRUN: assert property (orun_ev |=> ctc_overrun == 4'hf)
		else $error("overrun not flagged");
	AST_UNDERRUN: assert property (urun_ev |=> ctc_underrun == 4'hf ##1 1'b1)
		else $error("underrun not flagged");
	AST_NO_LANE0: assert property (!lane0_ok |-> !do_wr && !rd_go)
		else $error("fifo moved with lane 0 inactive");
	AST_GAP_DEL: assert property (del |-> gap_ff >= min_gap && level >= {1'b0, hi_mark})
		else $error("skip deleted too early");
	AST_LF: assert property (col_vld_ff && !filt_ff[5] |=>
		dec_ff == {LF_CTRL, LF_L3, LF_L2, LF_L1, LF_L0} ##2 rx_valid)
		else $error("local fault column missing");
	AST_LSM_RESTART: assert property ($changed(lsm_eff) |=> lsm_restart)
		else $error("link restart pulse missing");
	AST_RESYNC: assert property ($rose(filt_ff[6]) |=> align_resync)
		else $error("resync not passed to aligner");
	AST_EVENT: assert property (ev_en_ff[EV_ALIGNED] && $rose(aligned) |=> ev_ff[EV_ALIGNED])
		else $error("aligned event not latched");
	AST_INS_ONCE: assert property (ins |=> !ins [*1] ##0 rd_st_ff == RD_HELD)
		else $error("insertion repeated");
endmodule // xrcc_rx_comp
`default_nettype wire

// *** testbench/xrcc_fabric_rx.sv ***
// Purpose: Fabric-side receiver model that captures XGMII columns
// Assumes: Runs on the same clock as the block's reference side
// Notes:   Keeps the last column and a running count for the bench
`timescale 1ns/10ps
`default_nettype none
module xrcc_fabric_rx
	import xrcc_pkg::*;
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Receive column
	input  wire logic [31:0]      rxd,
	input  wire logic [3:0]       rxc,
	input  wire logic             rx_valid,
	// Capture
	output logic      [COL_W-1:0] last_col,
	output logic      [15:0]      col_cnt
);
	// ==========================================================
	// Capture
	// Fabric clock is the block's own clock, so no crossing here
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			last_col <= '0;
			col_cnt  <= 16'h0;
		end else if (rx_valid) begin
			last_col <= {rxc, rxd};
			col_cnt  <= col_cnt + 16'h1;
		end
	end
endmodule // xrcc_fabric_rx
`default_nettype wire

// *** testbench/test_xrcc_rx_comp.sv ***
// Purpose: Self-checking bench for the receive clock compensation block
// Assumes: Register reads answer one cycle after the strobe
// Notes:   Aligner clock runs only while alk_run is high
`timescale 1ns/10ps
`default_nettype none
module test_xrcc_rx_comp;
	import xrcc_pkg::*;
	// ==========================================================
	// Signals
	logic        clk, rst_n, algn_clk, alk_run, lane0_active, algn_aligned, resync;
	logic        felb_pin, lsm_en_pin, align_en_pin, tx_valid, reg_wr, reg_rd;
	logic [31:0] algn_data, tx_data, rxd, txo_data;
	logic [3:0]  algn_ctrl, lsm_status, tx_ctrl, rxc, txo_ctrl, align_lane_en;
	logic [3:0]  lsm_sync, ctc_underrun, ctc_overrun;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, got;
	logic        rx_valid, txo_valid, loopback_on, lsm_enable, lsm_restart;
	logic        align_resync, aligned, rst_seen;
	logic [35:0] last_col;
	logic [15:0] col_cnt, n0;
	logic [7:0]  kc [3];
	int          errors, checked, cycles, alk_half, i;
	// ==========================================================
	// Design and partner
	xrcc_rx_comp dut_u (.clk(clk), .rst_n(rst_n), .algn_clk(algn_clk),
		.algn_data(algn_data), .algn_ctrl(algn_ctrl), .lane0_active(lane0_active),
		.lsm_status(lsm_status), .algn_aligned(algn_aligned), .resync(resync),
		.felb_pin(felb_pin), .lsm_en_pin(lsm_en_pin), .align_en_pin(align_en_pin),
		.tx_data(tx_data), .tx_ctrl(tx_ctrl), .tx_valid(tx_valid),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .rxd(rxd), .rxc(rxc), .rx_valid(rx_valid),
		.txo_data(txo_data), .txo_ctrl(txo_ctrl), .txo_valid(txo_valid),
		.loopback_on(loopback_on), .lsm_enable(lsm_enable), .lsm_restart(lsm_restart),
		.align_lane_en(align_lane_en), .align_resync(align_resync),
		.lsm_sync(lsm_sync), .aligned(aligned), .ctc_underrun(ctc_underrun),
		.ctc_overrun(ctc_overrun));
	xrcc_fabric_rx fab_u (.clk(clk), .rst_n(rst_n), .rxd(rxd), .rxc(rxc),
		.rx_valid(rx_valid), .last_col(last_col), .col_cnt(col_cnt));
	// ==========================================================
	// Clocks and timeout
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Offset keeps aligner edges away from core edges
	initial begin
		algn_clk = 1'b0;
		#3;
		forever begin
			#(alk_half);
			algn_clk = alk_run ? ~algn_clk : 1'b0;
		end
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (lsm_restart === 1'b1)
			rst_seen <= 1'b1;
		if (cycles == 20000) begin
			errors++;
			$display("Error %0t: timeout", $time);
			summarize();
		end
	end
	// ==========================================================
	// Tasks
	task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("Error %0t: value %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_col(input logic [35:0] g, input logic [35:0] e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("Error %0t: column %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		chk_reg(reg_rdata & m, e);
	endtask
	task automatic stream(input logic [31:0] d, input logic [3:0] c, input int n);
		@(posedge clk);
		algn_data <= d;
		algn_ctrl <= c;
		alk_run   <= 1'b1;
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic done(input string s);
		$display("test %s done at %0t", s, $time);
	endtask
	task automatic summarize();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ==========================================================
	// Tests
	initial begin
		{rst_n, alk_run, lane0_active, algn_aligned, resync, felb_pin} = '0;
		{lsm_en_pin, align_en_pin, tx_valid, reg_wr, reg_rd, rst_seen} = '0;
		{algn_data, algn_ctrl, lsm_status, tx_data, tx_ctrl, reg_addr, reg_wdata} = '0;
		{errors, checked, cycles} = '0;
		alk_half = 40;
		kc = '{K_SKIP, K_ALIGN, K_SYNC};
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFS_WATER, 8'h97);
		rd(OFS_PAT_LO, 8'h1c);
		rd(OFS_PAT_HI, 8'h01);
		rd(OFS_GAP, 8'h00);
		wr(OFS_EV_EN, 8'h10);
		rd(OFS_EV_EN, 8'h10);
		for (i = 0; i < 4; i++) begin
			wr(OFS_GAP, {i[1:0], 6'h00});
			rd(OFS_GAP, {i[1:0], 6'h00});
		end
		wr(OFS_ALIGN_ST, 8'hff);
		rd(OFS_ALIGN_ST, 8'h00);
		rd(8'h3f, 8'h00);
		done("registers");
		lane0_active <= 1'b1;
		waitc(200);
		chk_reg({4'h0, ctc_underrun}, 8'h0f);
		rd(OFS_FIFO_ST, 8'h40, 8'h40);
		stream(32'h44332211, 4'h0, 400);
		chk_col(last_col, {LF_CTRL, LF_L3, LF_L2, LF_L1, LF_L0});
		done("fault");
		lsm_status   <= 4'ha;
		algn_aligned <= 1'b1;
		waitc(6);
		rd(OFS_LSM_ST, 8'ha0);
		chk_reg({4'h0, lsm_sync}, 8'h0a);
		rd(OFS_ALIGN_ST, 8'h04);
		chk_reg({7'h0, aligned}, 8'h01);
		rd(OFS_EV_FLAGS, 8'h10);
		rd(OFS_EV_FLAGS, 8'h10);
		stream(32'h44332211, 4'h0, 400);
		chk_col(last_col, {4'h0, 32'h44332211});
		for (i = 0; i < 3; i++) begin
			stream({4{kc[i]}}, 4'hf, 400);
			chk_col(last_col, {4'hf, {4{X_IDLE}}});
		end
		stream({8'h55, 8'h55, 8'h55, X_TERM}, 4'h1, 400);
		chk_col(last_col, {4'hf, {4{X_ERR}}});
		done("receive");
		lane0_active <= 1'b0;
		waitc(8);
		n0 = col_cnt;
		stream(32'h44332211, 4'h0, 200);
		chk_reg(8'(col_cnt - n0), 8'h00);
		lane0_active <= 1'b1;
		alk_half = 20;
		stream(32'h44332211, 4'h0, 400);
		chk_reg({4'h0, ctc_overrun}, 8'h0f);
		rd(OFS_FIFO_ST, 8'h80, 8'h80);
		// Fast skip columns: overrun until the gap reaches min_gap, then deletion keeps the full FIFO from overrunning
		stream({4{K_SKIP}}, 4'hf, 200);
		rd(OFS_FIFO_ST, 8'h80, 8'h80);
		waitc(100);
		chk_reg({4'h0, ctc_overrun}, 8'h00);
		alk_half = 40;
		done("flags");
		@(posedge clk);
		tx_data  <= 32'hcafe0123;
		tx_ctrl  <= 4'h5;
		tx_valid <= 1'b1;
		@(posedge clk);
		tx_valid <= 1'b0;
		for (i = 0; i < 4 && txo_valid !== 1'b1; i++)
			waitc(1);
		chk_col({txo_ctrl, txo_data}, {4'h5, 32'hcafe0123});
		wr(OFS_LANE_CTRL, 8'h20);
		waitc(3);
		chk_reg({7'h0, loopback_on}, 8'h01);
		rst_seen <= 1'b0;
		wr(OFS_LANE_CTRL, 8'h80);
		waitc(4);
		chk_reg({6'h0, loopback_on, lsm_enable}, 8'h01);
		chk_reg({7'h0, rst_seen}, 8'h01);
		wr(OFS_LANE_CTRL, 8'h00);
		felb_pin <= 1'b1;
		waitc(4);
		chk_reg({7'h0, loopback_on}, 8'h01);
		rst_seen   <= 1'b0;
		lsm_en_pin <= 1'b1;
		waitc(20);
		chk_reg({6'h0, rst_seen, lsm_enable}, 8'h03);
		chk_col({txo_ctrl, txo_data}, {4'hf, {4{K_SKIP}}});
		wr(OFS_ALIGN_EN, 8'h80);
		waitc(3);
		chk_reg({4'h0, align_lane_en}, 8'h01);
		wr(OFS_ALIGN_EN, 8'h10);
		waitc(3);
		chk_reg({4'h0, align_lane_en}, 8'h08);
		align_en_pin <= 1'b1;
		resync       <= 1'b1;
		waitc(8);
		chk_reg({4'h0, align_lane_en}, 8'h0f);
		chk_reg({7'h0, align_resync}, 8'h01);
		resync <= 1'b0;
		waitc(8);
		chk_reg({7'h0, align_resync}, 8'h00);
		done("control");
		summarize();
	end
endmodule // test_xrcc_rx_comp
`default_nettype wire
